// ---- rtl/adc_seq_pkg.sv ----
// Constants shared by the converter sequence controller and its helpers.
// Assumes a single core clock domain and APB access with byte addresses.
//
// Functional notes
// R1: Writing one to soft_reset_cmd returns every block register to its reset state.
// R2: Writing one to conv_enable_cmd enables the converter and starts its settle period.
// R3: Writing one to conv_disable_cmd puts the analog part into standby.
// R4: Writing one to start begins a sequence and clears result_valid_bit.
// R5: Writing one to stop halts an ongoing continuous sequence.
// R6: Software checks the ready flag before issuing a start command.
// R7: Converter clock equals core clock divided by four times clock_div_preload.
// R8: Divider count has its LSB forced to zero for fifty-percent duty.
// R9: Software keeps the converter clock at or below 700 kHz.
// R10: transfer_end_halts set stops continuous mode on transfer end; resets to zero.
// R11: settle_period_count core clocks elapse after enable before ready is reported.
// R12: sequence_length plus one conversions run, even in one-shot mode.
// R13: repeat_sequence zero runs the sequence once; one repeats it; resets to zero.
// R14: Eight three-bit order_slot_select fields pick the input of each conversion.
// R15: Writing one to overrun or transfer-done clear bits clears that flag.
// R16: result_valid_bit marks a valid result; reading result_register clears it.
// R17: Ready equals analog-ready and not converting; start is ignored while low.
// R18: result_overrun_flag sets when a result lands before the previous was read.
// R19: transfer_done_flag sets when the transfer controller finishes all results.
// R20: enabled_status reads one while the converter is enabled.
// R21: repeat_mode_status follows the repeat mode, resets to zero, never interrupts.
// R22: Clock gate status reads one while the block clock is enabled.
// R23: A conversion completes after eleven converter clocks; result latched, flag set.
// R24: Interrupt mask bits zero to three gate valid, ready, overrun, transfer-done.
// R25: Reading result_register clears result_valid_bit.
// R26: Interrupt output is high while any unmasked status flag is set.
package adc_seq_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CLK_GATE = 12'h058;
  localparam logic [11:0] OFF_COMMAND  = 12'h060;
  localparam logic [11:0] OFF_SEQ_CFG  = 12'h064;
  localparam logic [11:0] OFF_ORDER    = 12'h068;
  localparam logic [11:0] OFF_FLAG_CLR = 12'h06C;
  localparam logic [11:0] OFF_STATUS   = 12'h070;
  localparam logic [11:0] OFF_IRQ_SET  = 12'h074;
  localparam logic [11:0] OFF_RESULT   = 12'h080;

  localparam int CMD_SOFT_RESET = 0;
  localparam int CMD_ENABLE     = 1;
  localparam int CMD_DISABLE    = 2;
  localparam int CMD_START      = 3;
  localparam int CMD_STOP       = 4;

  localparam int CFG_PRELOAD_LSB = 0;
  localparam int PRELOAD_W       = 5;
  localparam int CFG_HALTS       = 6;
  localparam int CFG_SETTLE_LSB  = 8;
  localparam int SETTLE_W        = 8;
  localparam int CFG_LEN_LSB     = 16;
  localparam int SEL_W           = 3;
  localparam int CFG_REPEAT      = 19;

  localparam int ORDER_SLOTS  = 8;
  localparam int ORDER_STRIDE = 4;

  localparam int FLG_RESULT_VALID = 0;
  localparam int FLG_READY        = 1;
  localparam int FLG_OVERRUN      = 2;
  localparam int FLG_XFER_DONE    = 3;
  localparam int FLG_ENABLED      = 8;
  localparam int FLG_REPEAT       = 9;
  localparam int IRQ_SRC          = 4;
  localparam int CLK_GATE_BIT     = 1;

  localparam int RESULT_W = 10;
  localparam logic [3:0] CONV_TICKS = 4'hB;
  localparam logic [5:0] DIV_MIN    = 6'h02;
  localparam logic [5:0] DIV_LAST   = 6'h01;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;
endpackage : adc_seq_pkg

// ---- rtl/conv_clock_divider.sv ----
// Converter clock divider: a down-counter reloaded with an even value.
// Assumes run comes from the sequencer on the same core clock.
`timescale 1ns/1ps
module conv_clock_divider (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               run,
  input  wire logic [adc_seq_pkg::PRELOAD_W-1:0]  preload,
  output logic                                    tick,
  output logic                                    conv_clk
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       clk;
    logic       tick;
  } div_t;

  div_t       s;
  div_t       n;
  logic [5:0] half;

  always_comb begin
    half = {preload, 1'b0};                                   // [R8]
    if (half < adc_seq_pkg::DIV_MIN) begin
      half = adc_seq_pkg::DIV_MIN;
    end
    n = s;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = half;
      n.clk = 1'b0;
    end else if (s.cnt <= adc_seq_pkg::DIV_LAST) begin
      // Two half periods of 2*preload core clocks each
      n.cnt  = half;                                          // [R7]
      n.clk  = ~s.clk;
      n.tick = ~s.clk;
    end else begin
      n.cnt = s.cnt - adc_seq_pkg::DIV_LAST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick     = s.tick;
  assign conv_clk = s.clk;
endmodule : conv_clock_divider

// ---- rtl/settle_timer.sv ----
// Analog settle timer: counts core clocks after an enable before ready.
// Assumes on and go come from flops on the same core clock.
`timescale 1ns/1ps
module settle_timer (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              on,
  input  wire logic                              go,
  input  wire logic [adc_seq_pkg::SETTLE_W-1:0]  period,
  output logic                                   ready
);
  typedef struct packed {
    logic [adc_seq_pkg::SETTLE_W-1:0] cnt;
    logic                             busy;
    logic                             ready;
  } settle_t;

  settle_t s;
  settle_t n;

  always_comb begin
    n = s;
    if (!on) begin
      n = '0;
    end else if (go) begin
      n.cnt   = period;                                       // [R11]
      n.busy  = 1'b1;
      n.ready = 1'b0;
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        n.busy  = 1'b0;
        n.ready = 1'b1;
      end else begin
        n.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign ready = s.ready;
endmodule : settle_timer

// ---- rtl/adc_sequence_controller.sv ----
// Converter sequence controller: APB registers, sequencer and flags.
// Assumes the analog core, the transfer controller and the clock-gate
// source all run on pclk; their inputs need no synchroniser.
`timescale 1ns/1ps
module adc_sequence_controller (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [adc_seq_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                       pwdata,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              block_clock_on,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0]  conv_data,
  input  wire logic                              xfer_done,
  output logic                                   analog_on,
  output logic                                   conv_clk,
  output logic [adc_seq_pkg::SEL_W-1:0]          chan_sel,
  output logic                                   sample,
  output logic                                   result_ready,
  output logic                                   irq
);
  typedef struct packed {
    logic                                      pready;
    logic                                      pslverr;
    logic [31:0]                               prdata;
    logic                                      enabled;
    logic                                      settle_go;
    logic [adc_seq_pkg::PRELOAD_W-1:0]         preload;
    logic                                      halts;
    logic [adc_seq_pkg::SETTLE_W-1:0]          settle;
    logic [adc_seq_pkg::SEL_W-1:0]             length;
    logic                                      repeat_seq;
    logic [adc_seq_pkg::ORDER_SLOTS*adc_seq_pkg::SEL_W-1:0] order;
    logic [adc_seq_pkg::IRQ_SRC-1:0]           mask;
    logic                                      eoc;
    logic                                      result_overrun_flag;
    logic                                      transfer_done_flag;
    logic [adc_seq_pkg::RESULT_W-1:0]          result;
    adc_seq_pkg::seq_state_t                   state;
    logic [adc_seq_pkg::SEL_W-1:0]             slot;
    logic [3:0]                                ticks;
    logic [adc_seq_pkg::SEL_W-1:0]             chan;
    logic                                      sample;
    logic                                      dma_req;
    logic                                      irq;
  } ctl_t;

  ctl_t        s;
  ctl_t        n;
  logic        tick;
  logic        settle_ready;
  logic        ready_flag;
  logic        wr_acc;
  logic        rd_acc;
  logic        latch;
  logic [31:0] rd_mux;
  logic [adc_seq_pkg::IRQ_SRC-1:0] flags;

  localparam logic [3:0] CONV_LAST = adc_seq_pkg::CONV_TICKS - 4'h1;

  function automatic logic hit(input logic [adc_seq_pkg::ADDR_W-1:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [adc_seq_pkg::SEL_W-1:0] slot_sel(
      input logic [adc_seq_pkg::ORDER_SLOTS*adc_seq_pkg::SEL_W-1:0] ord,
      input logic [adc_seq_pkg::SEL_W-1:0] idx);
    slot_sel = ord[idx*adc_seq_pkg::SEL_W +: adc_seq_pkg::SEL_W];
  endfunction : slot_sel

  conv_clock_divider u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (s.state == adc_seq_pkg::SEQ_RUN),
    .preload  (s.preload),
    .tick     (tick),
    .conv_clk (conv_clk)
  );

  settle_timer u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .on      (s.enabled),
    .go      (s.settle_go),
    .period  (s.settle),
    .ready   (settle_ready)
  );

  assign ready_flag = settle_ready && (s.state == adc_seq_pkg::SEQ_IDLE);  // [R17]
  assign wr_acc = psel && penable && s.pready && pwrite;
  assign rd_acc = psel && penable && s.pready && !pwrite;
  assign latch  = (s.state == adc_seq_pkg::SEQ_RUN) && tick &&
                  (s.ticks == CONV_LAST);

  always_comb begin
    flags = '0;
    flags[adc_seq_pkg::FLG_RESULT_VALID] = s.eoc;
    flags[adc_seq_pkg::FLG_READY]        = ready_flag;
    flags[adc_seq_pkg::FLG_OVERRUN]      = s.result_overrun_flag;
    flags[adc_seq_pkg::FLG_XFER_DONE]    = s.transfer_done_flag;
  end

  always_comb begin
    rd_mux = '0;
    if (hit(paddr, adc_seq_pkg::OFF_CLK_GATE)) begin
      rd_mux[adc_seq_pkg::CLK_GATE_BIT] = block_clock_on;                 // [R22]
    end else if (hit(paddr, adc_seq_pkg::OFF_SEQ_CFG)) begin
      rd_mux[adc_seq_pkg::CFG_PRELOAD_LSB +: adc_seq_pkg::PRELOAD_W] = s.preload;
      rd_mux[adc_seq_pkg::CFG_HALTS] = s.halts;
      rd_mux[adc_seq_pkg::CFG_SETTLE_LSB +: adc_seq_pkg::SETTLE_W] = s.settle;
      rd_mux[adc_seq_pkg::CFG_LEN_LSB +: adc_seq_pkg::SEL_W] = s.length;
      rd_mux[adc_seq_pkg::CFG_REPEAT] = s.repeat_seq;
    end else if (hit(paddr, adc_seq_pkg::OFF_ORDER)) begin
      for (int i = 0; i < adc_seq_pkg::ORDER_SLOTS; i++) begin
        rd_mux[i*adc_seq_pkg::ORDER_STRIDE +: adc_seq_pkg::SEL_W] =
          s.order[i*adc_seq_pkg::SEL_W +: adc_seq_pkg::SEL_W];
      end
    end else if (hit(paddr, adc_seq_pkg::OFF_STATUS)) begin
      rd_mux[adc_seq_pkg::IRQ_SRC-1:0] = flags;
      rd_mux[adc_seq_pkg::FLG_ENABLED] = s.enabled;                      // [R20]
      rd_mux[adc_seq_pkg::FLG_REPEAT]  = s.repeat_seq;                   // [R21]
    end else if (hit(paddr, adc_seq_pkg::OFF_RESULT)) begin
      rd_mux[adc_seq_pkg::RESULT_W-1:0] = s.result;
    end
  end

  always_comb begin
    n = s;
    n.pready    = 1'b0;
    n.pslverr   = 1'b0;
    n.prdata    = '0;
    n.settle_go = 1'b0;
    n.dma_req   = 1'b0;
    // Zero-wait slave: answer is registered during the setup cycle
    if (psel && !penable) begin
      n.pready  = 1'b1;
      n.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
      n.pslverr = !(hit(paddr, adc_seq_pkg::OFF_CLK_GATE) ||
                    hit(paddr, adc_seq_pkg::OFF_COMMAND)  ||
                    hit(paddr, adc_seq_pkg::OFF_SEQ_CFG)  ||
                    hit(paddr, adc_seq_pkg::OFF_ORDER)    ||
                    hit(paddr, adc_seq_pkg::OFF_FLAG_CLR) ||
                    hit(paddr, adc_seq_pkg::OFF_STATUS)   ||
                    hit(paddr, adc_seq_pkg::OFF_IRQ_SET)  ||
                    hit(paddr, adc_seq_pkg::OFF_RESULT));
    end
    if (wr_acc && hit(paddr, adc_seq_pkg::OFF_SEQ_CFG)) begin
      n.preload    = pwdata[adc_seq_pkg::CFG_PRELOAD_LSB +: adc_seq_pkg::PRELOAD_W];
      n.halts      = pwdata[adc_seq_pkg::CFG_HALTS];
      n.settle     = pwdata[adc_seq_pkg::CFG_SETTLE_LSB +: adc_seq_pkg::SETTLE_W];
      n.length     = pwdata[adc_seq_pkg::CFG_LEN_LSB +: adc_seq_pkg::SEL_W];   // [R12]
      n.repeat_seq = pwdata[adc_seq_pkg::CFG_REPEAT];                       // [R13]
    end
    if (wr_acc && hit(paddr, adc_seq_pkg::OFF_ORDER)) begin
      for (int i = 0; i < adc_seq_pkg::ORDER_SLOTS; i++) begin
        n.order[i*adc_seq_pkg::SEL_W +: adc_seq_pkg::SEL_W] =
          pwdata[i*adc_seq_pkg::ORDER_STRIDE +: adc_seq_pkg::SEL_W];        // [R14]
      end
    end
    if (wr_acc && hit(paddr, adc_seq_pkg::OFF_IRQ_SET)) begin
      n.mask = s.mask | pwdata[adc_seq_pkg::IRQ_SRC-1:0];
    end
    // Clears first, so a hardware set in the same cycle wins
    if (rd_acc && hit(paddr, adc_seq_pkg::OFF_RESULT)) begin
      n.eoc = 1'b0;                                                        // [R25]
    end
    if (wr_acc && hit(paddr, adc_seq_pkg::OFF_FLAG_CLR)) begin
      if (pwdata[adc_seq_pkg::FLG_OVERRUN]) begin
        n.result_overrun_flag = 1'b0;                                                      // [R15]
      end
      if (pwdata[adc_seq_pkg::FLG_XFER_DONE]) begin
        n.transfer_done_flag = 1'b0;
      end
    end
    if (s.state == adc_seq_pkg::SEQ_RUN && tick) begin
      if (latch) begin
        n.result  = conv_data;                                             // [R23]
        n.eoc     = 1'b1;                                                  // [R16]
        n.result_overrun_flag     = s.result_overrun_flag | s.eoc;                                         // [R18]
        n.dma_req = 1'b1;
        n.ticks   = '0;
        if (s.slot == s.length) begin
          n.slot = '0;
          if (!s.repeat_seq) begin
            n.state = adc_seq_pkg::SEQ_IDLE;                               // [R13]
          end
        end else begin
          n.slot = s.slot + 1'b1;
        end
      end else begin
        n.ticks = s.ticks + 4'h1;
      end
    end
    if (xfer_done) begin
      n.transfer_done_flag = 1'b1;                                                       // [R19]
      if (s.halts && s.repeat_seq) begin
        n.state = adc_seq_pkg::SEQ_IDLE;                                   // [R10]
      end
    end
    if (wr_acc && hit(paddr, adc_seq_pkg::OFF_COMMAND)) begin
      if (pwdata[adc_seq_pkg::CMD_START] && ready_flag) begin
        n.state = adc_seq_pkg::SEQ_RUN;                                    // [R4]
        n.slot  = '0;
        n.ticks = '0;
        n.eoc   = 1'b0;
      end
      if (pwdata[adc_seq_pkg::CMD_STOP] && s.state == adc_seq_pkg::SEQ_RUN &&
          s.repeat_seq) begin
        n.state = adc_seq_pkg::SEQ_IDLE;                                   // [R5]
      end
      if (pwdata[adc_seq_pkg::CMD_ENABLE]) begin
        n.enabled   = 1'b1;                                                // [R2]
        n.settle_go = 1'b1;                                                // [R11]
      end
      if (pwdata[adc_seq_pkg::CMD_DISABLE]) begin
        // Disable wins over a same-write enable and aborts any sequence
        n.enabled   = 1'b0;                                                // [R3]
        n.settle_go = 1'b0;
        n.state     = adc_seq_pkg::SEQ_IDLE;
      end
    end
    n.chan   = slot_sel(n.order, n.slot);
    n.sample = (n.state == adc_seq_pkg::SEQ_RUN) && (n.ticks == '0);
    n.irq    = |(flags & s.mask);                                          // [R24] [R26]
    if (wr_acc && hit(paddr, adc_seq_pkg::OFF_COMMAND) &&
        pwdata[adc_seq_pkg::CMD_SOFT_RESET]) begin
      // Bus answer fields stay live; everything else returns to reset
      n = '{pready: n.pready, pslverr: n.pslverr, prdata: n.prdata,
            state: adc_seq_pkg::SEQ_IDLE, default: '0};                     // [R1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{state: adc_seq_pkg::SEQ_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end

  assign prdata       = s.prdata;
  assign pready       = s.pready;
  assign pslverr      = s.pslverr;
  assign analog_on    = s.enabled;
  assign chan_sel     = s.chan;
  assign sample       = s.sample;
  assign result_ready = s.dma_req;
  assign irq          = s.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence cmd_write(int b);
    wr_acc && hit(paddr, adc_seq_pkg::OFF_COMMAND) && pwdata[b];
  endsequence
  sequence plain_cmd;
    !pwdata[adc_seq_pkg::CMD_SOFT_RESET] && !pwdata[adc_seq_pkg::CMD_DISABLE];
  endsequence

  soft_reset_a: assert property (cmd_write(adc_seq_pkg::CMD_SOFT_RESET) |=> // [R1]
    s.mask == '0 && s.settle == '0 && !s.enabled && !s.repeat_seq && !s.halts)
    else $error("soft reset left state behind");
  enable_settle_a: assert property (cmd_write(adc_seq_pkg::CMD_ENABLE) // [R2]
    and plain_cmd |=> s.enabled ##1 !settle_ready)
    else $error("enable did not restart settle period");
  disable_cmd_a: assert property (cmd_write(adc_seq_pkg::CMD_DISABLE) // [R3]
    |=> !analog_on && s.state == adc_seq_pkg::SEQ_IDLE ##1 !settle_ready)
    else $error("disable did not reach standby");
  start_seq_a: assert property (cmd_write(adc_seq_pkg::CMD_START) and plain_cmd // [R4]
    and ready_flag |=> s.state == adc_seq_pkg::SEQ_RUN && !s.eoc ##1 sample)
    else $error("start did not begin a sequence");
  start_ignored_a: assert property (cmd_write(adc_seq_pkg::CMD_START) // [R17]
    && !ready_flag && s.state == adc_seq_pkg::SEQ_IDLE |=> s.state == adc_seq_pkg::SEQ_IDLE)
    else $error("start taken while not ready");
  stop_cont_a: assert property (cmd_write(adc_seq_pkg::CMD_STOP) // [R5]
    && s.state == adc_seq_pkg::SEQ_RUN && s.repeat_seq |=> s.state == adc_seq_pkg::SEQ_IDLE)
    else $error("stop did not halt continuous mode");
  halt_on_xfer_a: assert property (xfer_done && s.halts && s.repeat_seq && !wr_acc // [R10]
    |=> s.state == adc_seq_pkg::SEQ_IDLE && s.transfer_done_flag)
    else $error("transfer end did not halt");
  overrun_set_a: assert property (latch && s.eoc && !wr_acc |=> s.result_overrun_flag && s.eoc) // [R18]
    else $error("overrun not flagged");
  read_clear_a: assert property (rd_acc && hit(paddr, adc_seq_pkg::OFF_RESULT) // [R25]
    && !latch && !xfer_done |=> !s.eoc)
    else $error("result read did not clear valid flag");
  // Soft reset clears the interrupt register ahead of the flags
  irq_gate_a: assert property (!(wr_acc && hit(paddr, adc_seq_pkg::OFF_COMMAND) // [R26]
    && pwdata[adc_seq_pkg::CMD_SOFT_RESET]) |=> irq == $past(|(flags & s.mask)))
    else $error("interrupt does not match masked flags");
endmodule : adc_sequence_controller

// ---- tb/conv_core_model.sv ----
// Far-side model: analog core result source and transfer controller.
// Assumes the controller's sample, chan_sel and result_ready on pclk.
`timescale 1ns/1ps
module conv_core_model #(
  parameter int BATCH = 2
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             sample,
  input  wire logic [adc_seq_pkg::SEL_W-1:0]    chan_sel,
  input  wire logic                             result_ready,
  output logic [adc_seq_pkg::RESULT_W-1:0]      conv_data,
  output logic                                  xfer_done
);
  logic [2:0] held_q;
  logic [3:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q    <= 3'h0;
      cnt_q     <= 4'h0;
      xfer_done <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      if (sample) held_q <= chan_sel;
      // Done pulse after every BATCH results moved
      if (result_ready && cnt_q == 4'(BATCH - 1)) begin
        cnt_q     <= 4'h0;
        xfer_done <= 1'b1;
      end else if (result_ready) cnt_q <= cnt_q + 4'h1;
    end
  end
  // Result names its input so slot order shows in the data
  assign conv_data = {7'h2A, held_q};
endmodule : conv_core_model

// ---- tb/adc_sequence_controller_tb.sv ----
// Self-checking bench for the converter sequence controller.
// Assumes zero-wait APB answers and a far-side model batch of two.
`timescale 1ns/1ps
module adc_sequence_controller_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        block_clock_on, xfer_done, analog_on, conv_clk, sample;
  logic        result_ready, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  chan_sel;
  logic [9:0]  conv_data;
  int          fail_count, total_checks;
  int          res_cnt = 0;

  adc_sequence_controller u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .block_clock_on(block_clock_on), .conv_data(conv_data), .xfer_done(xfer_done),
    .analog_on(analog_on), .conv_clk(conv_clk), .chan_sel(chan_sel),
    .sample(sample), .result_ready(result_ready), .irq(irq));
  conv_core_model #(.BATCH(2)) u_core (.pclk(pclk), .presetn(presetn),
    .sample(sample), .chan_sel(chan_sel), .result_ready(result_ready),
    .conv_data(conv_data), .xfer_done(xfer_done));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (result_ready === 1'b1) res_cnt <= res_cnt + 1;

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic timeout(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      print_verdict();
    end
  endtask : timeout

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer read at the rising edge, before the slave's own update
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    timeout(n, 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  task automatic wait_res(input int k);
    int n;
    for (n = 0; n < 600; n++) begin
      @(negedge pclk);
      if (res_cnt >= k) break;
    end
    timeout(n, 600);
  endtask : wait_res

  // Software polls ready before a start
  task automatic go();
    int n;
    for (n = 0; n < 40; n++) begin
      apb(1'b0, adc_seq_pkg::OFF_STATUS, 32'h0);
      if (rd[1] === 1'b1) break;
    end
    timeout(n, 40);
    apb(1'b1, adc_seq_pkg::OFF_COMMAND, 32'h8);
  endtask : go

  task automatic t_reset_vals();
    rdchk(adc_seq_pkg::OFF_SEQ_CFG, 32'h0, "cfg");
    rdchk(adc_seq_pkg::OFF_ORDER, 32'h0, "order");
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h0, "status");
    rdchk(adc_seq_pkg::OFF_CLK_GATE, 32'h2, "clk_gate");
    apb(1'b0, 12'h05C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
  endtask : t_reset_vals

  task automatic t_oneshot();
    int base;
    int k;
    // Fast divider keeps the run short; real parts need a slower one
    apb(1'b1, adc_seq_pkg::OFF_SEQ_CFG, 32'h0001_0401);
    apb(1'b1, adc_seq_pkg::OFF_ORDER, 32'h0000_0035);
    apb(1'b1, adc_seq_pkg::OFF_IRQ_SET, 32'h1);
    apb(1'b1, adc_seq_pkg::OFF_COMMAND, 32'h2);
    base = res_cnt;
    go();
    chk("analog_on", 32'h1, {31'h0, analog_on});
    k = 0;
    while (conv_clk !== 1'b1 && k < 50) begin
      @(negedge pclk);
      k++;
    end
    k = 0;
    while (conv_clk === 1'b1 && k < 50) begin
      @(negedge pclk);
      k++;
    end
    while (conv_clk !== 1'b1 && k < 50) begin
      @(negedge pclk);
      k++;
    end
    chk("conv_clk_period", 32'h4, 32'(k));
    wait_res(base + 1);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    rdchk(adc_seq_pkg::OFF_RESULT, 32'h155, "slot0");
    repeat (2) @(negedge pclk);
    chk("irq_off", 32'h0, {31'h0, irq});
    wait_res(base + 2);
    rdchk(adc_seq_pkg::OFF_RESULT, 32'h153, "slot1");
    repeat (200) @(negedge pclk);
    chk("one_shot", 32'(base + 2), 32'(res_cnt));
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h10A, "status");
    apb(1'b1, adc_seq_pkg::OFF_FLAG_CLR, 32'hC);
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h102, "cleared");
  endtask : t_oneshot

  task automatic t_repeat();
    int base;
    apb(1'b1, adc_seq_pkg::OFF_SEQ_CFG, 32'h0008_0441);
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h302, "repeat_mode");
    base = res_cnt;
    go();
    wait_res(base + 2);
    repeat (300) @(negedge pclk);
    chk("halted", 32'(base + 2), 32'(res_cnt));
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h30F, "overrun");
  endtask : t_repeat

  task automatic t_soft();
    apb(1'b1, adc_seq_pkg::OFF_COMMAND, 32'h4);
    @(negedge pclk);
    chk("analog_off", 32'h0, {31'h0, analog_on});
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h20D, "disabled");
    apb(1'b1, adc_seq_pkg::OFF_COMMAND, 32'h1);
    rdchk(adc_seq_pkg::OFF_SEQ_CFG, 32'h0, "cfg_reset");
    rdchk(adc_seq_pkg::OFF_STATUS, 32'h0, "status_reset");
  endtask : t_soft

  initial begin
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0;
    block_clock_on = 1'b1;
    fail_count     = 0;
    total_checks   = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_oneshot();
    t_repeat();
    t_soft();
    print_verdict();
  end
endmodule : adc_sequence_controller_tb
